// ===== hdl/atw_consts.vh
// register map, field positions and reset values of the converter trigger/wrap block
`ifndef ATW_CONSTS_VH
`define ATW_CONSTS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define ATW_IDX_W            5
`define ATW_IDX_WRAP         5'h00
`define ATW_IDX_TRIG         5'h01
`define ATW_IDX_TCTL         5'h02
`define ATW_IDX_SEQ          5'h05
`define ATW_IDX_STAT         5'h06
`define ATW_IDX_DIEN_HI      5'h0C
`define ATW_IDX_DIEN_LO      5'h0D
`define ATW_IDX_PIN_HI       5'h0E
`define ATW_IDX_PIN_LO       5'h0F
`define ATW_IDX_RES_BASE     5'h10

// ****************************************
// field positions
// ****************************************
`define ATW_WRAP_MSB         3
`define ATW_WRAP_LSB         0
`define ATW_TRIG_TYPE_BIT    7
`define ATW_TRIG_CH_MSB      3
`define ATW_TRIG_CH_LSB      0
`define ATW_TCTL_LE_BIT      4
`define ATW_TCTL_POL_BIT     3
`define ATW_TCTL_EN_BIT      2
`define ATW_SEQ_MULTI_CHANNEL_MODE_BIT     4
`define ATW_SEQ_CH_MSB       3
`define ATW_SEQ_CH_LSB       0
`define ATW_STAT_DONE_BIT    7
`define ATW_STAT_BUSY_BIT    6

// ****************************************
// reset values and constants
// ****************************************
`define ATW_WRAP_RST         4'hF
`define ATW_TRIG_RST         8'h00
`define ATW_TCTL_RST         8'h00
`define ATW_SEQ_RST          8'h00
`define ATW_DIEN_RST         8'h00
`define ATW_RES_PAD          6'h00
`define ATW_RESP_OKAY        2'h0
`define ATW_RESP_SLVERR      2'h2
`define ATW_DED_HI_ZERO      2'h0

`endif

// ===== hdl/atw_sync.v
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none

module atw_sync #(
	parameter WIDTH = 20
) (
	input  wire             sys_clk_i,
	input  wire             rst_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			reg meta_r;
			reg stab_r;
			// first stage feeds only the second stage
			always @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i) begin
					meta_r <= 1'b0;
					stab_r <= 1'b0;
				end else begin
					meta_r <= async_i[g];
					stab_r <= meta_r;
				end
			end
			assign sync_o[g] = stab_r;
		end
	endgenerate

endmodule // atw_sync

`default_nettype wire

// ===== hdl/atw_trig_detect.v
// trigger sensitivity detector: edge or level, either polarity
`timescale 1ns/1ps
`default_nettype none

module atw_trig_detect (
	input  wire sys_clk_i,
	input  wire rst_i,
	input  wire level_i,
	input  wire level_edge_i,
	input  wire polarity_i,
	output wire hit_o
);

	reg prev_r;

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= level_i;
		end
	end

	// 00 falling, 01 rising, 10 low level, 11 high level
	assign hit_o = level_edge_i ? (level_i == polarity_i) :
		(polarity_i ? (level_i & ~prev_r) : (~level_i & prev_r));

endmodule // atw_trig_detect

`default_nettype wire

// ===== hdl/atw_top.v
// converter wrap-around and external trigger control with AXI4-Lite register slave
//
// Behaviour
// - writing wrap or trigger-source register aborts a running sequence, never starts one.
// - multi-channel mode returns to channel 0 after the wrap channel; wrap 0 reserved.
// - source-type bit picks analog pin (0) or dedicated trigger input (1).
// - with type 0 the 4-bit channel field selects analog channel 0..15.
// - with type 1 codes 0..3 select trigger inputs 0..3; others reserved.
// - without dedicated inputs the type bit is stored but ignored.
// - wrap and trigger-source registers are readable and writable at any time.
// - trigger starts conversions only when enabled; analog trigger enables its input buffer.
// - level/edge and polarity bits: falling, rising, low level, high level.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "atw_consts.vh"

module atw_top #(
	parameter       ADDR_W         = 7,
	parameter [4:0] SEQ_LEN        = 5'h04,
	parameter       DED_TRIG_AVAIL = 1
) (
	input  wire              sys_clk_i,
	input  wire              rst_i,
	// AXI4-Lite slave
	input  wire [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire              s_axi_awvalid_i,
	output wire              s_axi_awready_o,
	input  wire [31:0]       s_axi_wdata_i,
	input  wire [3:0]        s_axi_wstrb_i,
	input  wire              s_axi_wvalid_i,
	output wire              s_axi_wready_o,
	output wire [1:0]        s_axi_bresp_o,
	output wire              s_axi_bvalid_o,
	input  wire              s_axi_bready_i,
	input  wire [ADDR_W-1:0] s_axi_araddr_i,
	input  wire              s_axi_arvalid_i,
	output wire              s_axi_arready_o,
	output wire [31:0]       s_axi_rdata_o,
	output wire [1:0]        s_axi_rresp_o,
	output wire              s_axi_rvalid_o,
	input  wire              s_axi_rready_i,
	// pins and converter core
	input  wire [15:0]       analog_channel_pin_i,
	input  wire [3:0]        dedicated_trigger_input_i,
	output wire [15:0]       digital_input_enable_o,
	output wire              conv_req_o,
	output wire [3:0]        conv_chan_o,
	input  wire              conv_done_i,
	input  wire [9:0]        conv_result_i
);

	// ****************************************
	// synchronised pins
	// ****************************************
	wire [19:0] pins_sync;
	wire [15:0] ana_sync;
	wire [3:0]  ded_sync;

	atw_sync #(
		.WIDTH (20)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.async_i   ({dedicated_trigger_input_i, analog_channel_pin_i}),
		.sync_o    (pins_sync)
	);

	assign ana_sync = pins_sync[15:0];
	assign ded_sync = pins_sync[19:16];

	// ****************************************
	// registers
	// ****************************************
	reg [3:0]  wrap_channel_control_r;
	reg [7:0]  trigger_source_control_r;
	reg [7:0]  trig_ctl_r;
	reg [7:0]  seq_ctl_r;
	reg [7:0]  dien_hi_r;
	reg [7:0]  dien_lo_r;
	reg [9:0]  result_r [0:15];
	reg        done_flag_r;
	reg        busy_r;
	reg [3:0]  chan_r;
	reg [3:0]  slot_r;
	reg        conv_req_r;
	reg [15:0] dien_out_r;

	// bus state
	reg              awready_r;
	reg              wready_r;
	reg              have_aw_r;
	reg              have_w_r;
	reg [ADDR_W-1:0] awaddr_r;
	reg [31:0]       wdata_r;
	reg [3:0]        wstrb_r;
	reg              bvalid_r;
	reg [1:0]        bresp_r;
	reg              arready_r;
	reg              rvalid_r;
	reg [31:0]       rdata_r;
	reg [1:0]        rresp_r;

	// ****************************************
	// write channel capture
	// ****************************************
	wire aw_hs = s_axi_awvalid_i & awready_r;
	wire w_hs  = s_axi_wvalid_i & wready_r;
	wire aw_ok = have_aw_r | aw_hs;
	wire w_ok  = have_w_r | w_hs;
	wire wr_fire = aw_ok & w_ok & ~bvalid_r;

	wire [ADDR_W-1:0] wr_addr = have_aw_r ? awaddr_r : s_axi_awaddr_i;
	wire [31:0]       wr_data = have_w_r ? wdata_r : s_axi_wdata_i;
	wire [3:0]        wr_strb = have_w_r ? wstrb_r : s_axi_wstrb_i;
	wire [4:0]        wr_idx  = wr_addr[6:2];
	wire              wr_lane = wr_fire & wr_strb[0];

	wire wr_wrap = wr_lane & (wr_idx == `ATW_IDX_WRAP);
	wire wr_trig = wr_lane & (wr_idx == `ATW_IDX_TRIG);
	wire wr_tctl = wr_lane & (wr_idx == `ATW_IDX_TCTL);
	wire wr_seq  = wr_lane & (wr_idx == `ATW_IDX_SEQ);
	wire wr_stat = wr_lane & (wr_idx == `ATW_IDX_STAT);
	wire wr_dhi  = wr_lane & (wr_idx == `ATW_IDX_DIEN_HI);
	wire wr_dlo  = wr_lane & (wr_idx == `ATW_IDX_DIEN_LO);

	reg wr_mapped;
	always @* begin
		case (wr_idx)
			`ATW_IDX_WRAP, `ATW_IDX_TRIG, `ATW_IDX_TCTL, `ATW_IDX_SEQ,
			`ATW_IDX_STAT, `ATW_IDX_DIEN_HI, `ATW_IDX_DIEN_LO: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	// ****************************************
	// trigger source selection
	// ****************************************
	wire       trig_en   = trig_ctl_r[`ATW_TCTL_EN_BIT];
	wire [3:0] trig_code = trigger_source_control_r[`ATW_TRIG_CH_MSB:`ATW_TRIG_CH_LSB];
	// when dedicated inputs are absent the stored type bit has no effect
	wire type_eff = (DED_TRIG_AVAIL != 0) & trigger_source_control_r[`ATW_TRIG_TYPE_BIT];
	wire code_ok  = ~type_eff | (trig_code[3:2] == `ATW_DED_HI_ZERO);
	wire src_lvl  = type_eff ? ded_sync[trig_code[1:0]] : ana_sync[trig_code];
	wire trig_hit;

	atw_trig_detect u_detect (
		.sys_clk_i    (sys_clk_i),
		.rst_i        (rst_i),
		.level_i      (src_lvl),
		.level_edge_i (trig_ctl_r[`ATW_TCTL_LE_BIT]),
		.polarity_i   (trig_ctl_r[`ATW_TCTL_POL_BIT]),
		.hit_o        (trig_hit)
	);

	// ****************************************
	// sequence engine
	// ****************************************
	// writes to wrap, trigger-source or trigger control abort; they never start
	wire abort_wr  = wr_wrap | wr_trig | wr_tctl;
	wire sw_start  = wr_seq & ~trig_en;
	wire hw_start  = trig_en & trig_hit & code_ok & ~busy_r;
	wire start     = ~abort_wr & (sw_start | hw_start);
	wire multi     = seq_ctl_r[`ATW_SEQ_MULTI_CHANNEL_MODE_BIT];
	wire [3:0] wrap_at = (wrap_channel_control_r == 4'h0) ? 4'hF : wrap_channel_control_r;
	wire [4:0] seq_last = SEQ_LEN - 5'h01;
	wire conv_ok   = busy_r & conv_req_r & conv_done_i & ~abort_wr;
	wire last_slot = ({1'b0, slot_r} == seq_last);
	wire [3:0] first_ch = wr_seq ? wr_data[`ATW_SEQ_CH_MSB:`ATW_SEQ_CH_LSB] :
		seq_ctl_r[`ATW_SEQ_CH_MSB:`ATW_SEQ_CH_LSB];
	wire clr_done  = wr_stat & wr_data[`ATW_STAT_DONE_BIT];

	reg [3:0] chan_nxt;
	always @* begin
		if (multi) begin
			chan_nxt = (chan_r == wrap_at) ? 4'h0 : chan_r + 4'h1;
		end else begin
			chan_nxt = chan_r;
		end
	end

	integer i;
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_r      <= 1'b0;
			conv_req_r  <= 1'b0;
			chan_r      <= 4'h0;
			slot_r      <= 4'h0;
			done_flag_r <= 1'b0;
			for (i = 0; i < 16; i = i + 1) begin
				result_r[i] <= 10'h000;
			end
		end else begin
			if (abort_wr) begin
				busy_r     <= 1'b0;
				conv_req_r <= 1'b0;
			end else if (start) begin
				busy_r     <= 1'b1;
				conv_req_r <= 1'b1;
				chan_r     <= first_ch;
				slot_r     <= 4'h0;
			end else if (conv_ok) begin
				result_r[slot_r] <= conv_result_i;
				if (last_slot) begin
					busy_r     <= 1'b0;
					conv_req_r <= 1'b0;
				end else begin
					slot_r <= slot_r + 4'h1;
					chan_r <= chan_nxt;
				end
			end
			// completion set wins over a clear in the same cycle
			if (conv_ok & last_slot) begin
				done_flag_r <= 1'b1;
			end else if (clr_done | start) begin
				done_flag_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// control registers and input buffer enables
	// ****************************************
	wire [15:0] trig_buf = (trig_en & ~type_eff) ? (16'h0001 << trig_code) : 16'h0000;
	wire [15:0] dien_all = {dien_hi_r, dien_lo_r};

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wrap_channel_control_r   <= `ATW_WRAP_RST;
			trigger_source_control_r <= `ATW_TRIG_RST;
			trig_ctl_r               <= `ATW_TCTL_RST;
			seq_ctl_r                <= `ATW_SEQ_RST;
			dien_hi_r                <= `ATW_DIEN_RST;
			dien_lo_r                <= `ATW_DIEN_RST;
			dien_out_r               <= 16'h0000;
		end else begin
			if (wr_wrap) begin
				wrap_channel_control_r <= wr_data[`ATW_WRAP_MSB:`ATW_WRAP_LSB];
			end
			if (wr_trig) begin
				// type bit always stored, even with no dedicated inputs
				trigger_source_control_r <= {wr_data[`ATW_TRIG_TYPE_BIT], 3'h0,
					wr_data[`ATW_TRIG_CH_MSB:`ATW_TRIG_CH_LSB]};
			end
			if (wr_tctl) begin
				trig_ctl_r <= {3'h0, wr_data[`ATW_TCTL_LE_BIT], wr_data[`ATW_TCTL_POL_BIT],
					wr_data[`ATW_TCTL_EN_BIT], 2'h0};
			end
			if (wr_seq) begin
				seq_ctl_r <= {3'h0, wr_data[`ATW_SEQ_MULTI_CHANNEL_MODE_BIT],
					wr_data[`ATW_SEQ_CH_MSB:`ATW_SEQ_CH_LSB]};
			end
			if (wr_dhi) begin
				dien_hi_r <= wr_data[7:0];
			end
			if (wr_dlo) begin
				dien_lo_r <= wr_data[7:0];
			end
			dien_out_r <= dien_all | trig_buf;
		end
	end

	// ****************************************
	// read decode
	// ****************************************
	wire [4:0]  rd_idx = s_axi_araddr_i[6:2];
	wire [15:0] pin_rd = ana_sync & dien_out_r;
	reg  [31:0] rd_data;
	reg         rd_ok;
	always @* begin
		rd_data = 32'h00000000;
		rd_ok   = 1'b1;
		case (rd_idx)
			`ATW_IDX_WRAP:    rd_data = {28'h0000000, wrap_channel_control_r};
			`ATW_IDX_TRIG:    rd_data = {24'h000000, trigger_source_control_r};
			`ATW_IDX_TCTL:    rd_data = {24'h000000, trig_ctl_r};
			`ATW_IDX_SEQ:     rd_data = {24'h000000, seq_ctl_r};
			`ATW_IDX_STAT:    rd_data = {24'h000000, done_flag_r, busy_r, 2'h0, chan_r};
			`ATW_IDX_DIEN_HI: rd_data = {24'h000000, dien_hi_r};
			`ATW_IDX_DIEN_LO: rd_data = {24'h000000, dien_lo_r};
			`ATW_IDX_PIN_HI:  rd_data = {24'h000000, pin_rd[15:8]};
			`ATW_IDX_PIN_LO:  rd_data = {24'h000000, pin_rd[7:0]};
			default: begin
				if (rd_idx[4]) begin
					rd_data = {16'h0000, result_r[rd_idx[3:0]], `ATW_RES_PAD};
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			have_aw_r <= 1'b0;
			have_w_r  <= 1'b0;
			awaddr_r  <= {ADDR_W{1'b0}};
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `ATW_RESP_OKAY;
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `ATW_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				awready_r <= 1'b0;
				awaddr_r  <= s_axi_awaddr_i;
			end
			if (w_hs) begin
				wready_r <= 1'b0;
				wdata_r  <= s_axi_wdata_i;
				wstrb_r  <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				have_aw_r <= 1'b0;
				have_w_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_mapped ? `ATW_RESP_OKAY : `ATW_RESP_SLVERR;
			end else begin
				if (aw_hs) begin
					have_aw_r <= 1'b1;
				end
				if (w_hs) begin
					have_w_r <= 1'b1;
				end
			end
			// one write in flight: channels reopen once the response is taken
			if (bvalid_r & s_axi_bready_i) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
			if (s_axi_arvalid_i & arready_r) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rd_data;
				rresp_r   <= rd_ok ? `ATW_RESP_OKAY : `ATW_RESP_SLVERR;
			end else if (rvalid_r & s_axi_rready_i) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	assign s_axi_awready_o        = awready_r;
	assign s_axi_wready_o         = wready_r;
	assign s_axi_bresp_o          = bresp_r;
	assign s_axi_bvalid_o         = bvalid_r;
	assign s_axi_arready_o        = arready_r;
	assign s_axi_rdata_o          = rdata_r;
	assign s_axi_rresp_o          = rresp_r;
	assign s_axi_rvalid_o         = rvalid_r;
	assign digital_input_enable_o = dien_out_r;
	assign conv_req_o             = conv_req_r;
	assign conv_chan_o            = chan_r;

endmodule // atw_top

`default_nettype wire

// ===== testbench/atw_top_sva.sv
// port assertions for the converter trigger/wrap block
`timescale 1ns/1ps
`default_nettype none
`include "atw_consts.vh"
module atw_top_sva #(
	parameter ADDR_W = 7
) (
	input wire logic              sys_clk_i,
	input wire logic              rst_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic              s_axi_awvalid_i,
	input wire logic              s_axi_awready_o,
	input wire logic              s_axi_wvalid_i,
	input wire logic              s_axi_wready_o,
	input wire logic [1:0]        s_axi_bresp_o,
	input wire logic              s_axi_bvalid_o,
	input wire logic              s_axi_bready_i,
	input wire logic              s_axi_arvalid_i,
	input wire logic              s_axi_arready_o,
	input wire logic [31:0]       s_axi_rdata_o,
	input wire logic              s_axi_rvalid_o,
	input wire logic              s_axi_rready_i,
	input wire logic              conv_req_o,
	input wire logic              conv_done_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire [4:0] aw_idx = s_axi_awaddr_i[ADDR_W-1:2];
	sequence s_wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	// wrap, trigger source and trigger control share the abort behaviour
	sequence s_ctl_wr;
		s_wr_take ##0 (aw_idx <= `ATW_IDX_TCTL);
	endsequence
	a_b_follows: assert property (s_wr_take |=> s_axi_bvalid_o)
		else $error("write response missing");
	a_b_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");
	a_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write accepted during response");
	a_r_follows: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data missing");
	a_r_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data changed early");
	a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read accepted during data phase");
	a_ctl_abort: assert property (s_ctl_wr |=> !conv_req_o)
		else $error("control write left sequence running");
	a_seq_hold: assert property (conv_req_o && !conv_done_i && !(s_axi_awvalid_i || s_axi_wvalid_i) |=> conv_req_o)
		else $error("sequence stopped without cause");
	a_rd_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");
endmodule // atw_top_sva
bind atw_top atw_top_sva #(.ADDR_W(ADDR_W)) u_sva (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(s_axi_awaddr_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .conv_req_o(conv_req_o), .conv_done_i(conv_done_i)
);
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench: register access, sequences, aborts and trigger selection
`timescale 1ns/1ps
`default_nettype none
`include "atw_consts.vh"
module tb;
	logic        clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, arv = 1'h0;
	logic        bre = 1'h1, rre = 1'h1, dn = 1'h0;
	logic [6:0]  awa = 7'h00, ara = 7'h00;
	logic [31:0] wd = 32'h0;
	logic [15:0] pin = 16'h0;
	logic [3:0]  ded = 4'h0;
	logic [9:0]  res = 10'h0;
	logic [3:0]  exp_ch [4] = '{4'h1, 4'h2, 4'h0, 4'h1};
	wire         awr, wrdy, bv, arr, rv, req;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdat;
	wire  [15:0] dien;
	wire  [3:0]  ch;
	int          miscompares = 0, total_checks = 0, i;
	localparam logic [1:0] OK = `ATW_RESP_OKAY, SE = `ATW_RESP_SLVERR;
	atw_top #(.SEQ_LEN(5'h04)) u_dut (
		.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .analog_channel_pin_i(pin), .dedicated_trigger_input_i(ded),
		.digital_input_enable_o(dien), .conv_req_o(req), .conv_chan_o(ch), .conv_done_i(dn), .conv_result_i(res)
	);
	initial forever #10 clk = ~clk;
	task automatic report_and_stop;
		if (miscompares == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 40) begin
			miscompares++;
			$display("[FAIL] %0t bus wait ran out", $time);
			report_and_stop;
		end
	endtask
	// st holds the ready low for a while so the response must stand
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e, input int st = 0);
		int n = 0;
		@(posedge clk);
		awa <= {a, 2'h0};
		wd <= {24'h0, d};
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= (st == 0);
		do begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wrdy) wv <= 1'h0;
			if (n == st) bre <= 1'h1;
			n++;
		end while (!(bv && bre) && n < 40);
		tmo(n);
		chk({30'h0, bresp}, {30'h0, e});
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er, input int st = 0);
		int n = 0;
		@(posedge clk);
		ara <= {a, 2'h0};
		arv <= 1'h1;
		rre <= (st == 0);
		do begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
			if (n == st) rre <= 1'h1;
			n++;
		end while (!(rv && rre) && n < 40);
		tmo(n);
		chk(rdat, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	task automatic done_p(input logic [9:0] v);
		@(posedge clk);
		res <= v;
		dn <= 1'h1;
		@(posedge clk);
		dn <= 1'h0;
		@(negedge clk);
	endtask
	// trigger latency runs through the pin synchroniser, so allow a few cycles
	task automatic wait_req;
		int n = 0;
		while (req !== 1'h1 && n < 12) begin
			@(negedge clk);
			n++;
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		rd(`ATW_IDX_WRAP, 32'h0F, OK);
		rd(`ATW_IDX_TRIG, 32'h00, OK, 3);
		rd(5'h07, 32'h00, SE);
		wr(`ATW_IDX_PIN_LO, 8'hFF, SE, 3);
		wr(`ATW_IDX_WRAP, 8'h02, OK);
		wr(`ATW_IDX_SEQ, 8'h11, OK);
		for (i = 0; i < 4; i++) begin
			@(negedge clk);
			chk({31'h0, req}, 32'h1);
			chk({28'h0, ch}, {28'h0, exp_ch[i]});
			done_p({8'hA0, i[1:0]});
		end
		chk({31'h0, req}, 32'h0);
		for (i = 0; i < 4; i++)
			rd({3'h4, i[1:0]}, {16'h0, 8'hA0, i[1:0], 6'h0}, OK);
		// done set, not busy, channel left on the last one converted
		rd(`ATW_IDX_STAT, 32'h81, OK);
		for (i = 0; i < 3; i++) begin
			wr(`ATW_IDX_SEQ, 8'h03, OK);
			@(negedge clk);
			chk({31'h0, req}, 32'h1);
			wr(i[4:0], 8'h0C, OK);
			@(negedge clk);
			chk({31'h0, req}, 32'h0);
			rd(i[4:0], 32'h0C, OK);
		end
		wr(`ATW_IDX_TCTL, 8'h00, OK);
		wr(`ATW_IDX_TRIG, 8'h05, OK);
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			pin[5] <= ~i[0];
			repeat (4) @(posedge clk);
			wr(`ATW_IDX_TCTL, {3'h0, i[1:0], 3'h4}, OK);
			repeat (8) @(negedge clk);
			chk({16'h0, dien}, 32'h20);
			chk({31'h0, req}, 32'h0);
			rd(`ATW_IDX_PIN_LO, {26'h0, ~i[0], 5'h0}, OK);
			@(posedge clk);
			pin[5] <= i[0];
			wait_req;
			chk({31'h0, req}, 32'h1);
			wr(`ATW_IDX_TCTL, 8'h00, OK);
		end
		wr(`ATW_IDX_TCTL, 8'h18, OK);
		repeat (8) @(negedge clk);
		chk({31'h0, req}, 32'h0);
		chk({16'h0, dien}, 32'h0);
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			ded <= 4'h0;
			wr(`ATW_IDX_TCTL, 8'h00, OK);
			wr(`ATW_IDX_TRIG, 8'h80 | i[7:0], OK);
			rd(`ATW_IDX_TRIG, 32'h80 | i, OK);
			wr(`ATW_IDX_TCTL, 8'h0C, OK);
			@(posedge clk);
			ded <= ~(4'h1 << i);
			repeat (8) @(negedge clk);
			chk({31'h0, req}, 32'h0);
			@(posedge clk);
			ded <= 4'hF;
			wait_req;
			chk({31'h0, req}, {31'h0, i < 4});
		end
		// mid-run reset while a software sequence is running
		wr(`ATW_IDX_TCTL, 8'h00, OK);
		wr(`ATW_IDX_SEQ, 8'h03, OK);
		@(negedge clk);
		chk({31'h0, req}, 32'h1);
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		chk({27'h0, req, ch}, 32'h0);
		chk({16'h0, dien}, 32'h0);
		rd(`ATW_IDX_WRAP, 32'h0F, OK);
		rd(`ATW_IDX_STAT, 32'h00, OK);
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
